//--- shared/dti_pkg.sv
/*
 Shared constants and carrier types for the double-to-integer converter.
 Assumes a 32-bit APB register bus and a decoder that presents one
 instruction at a time on the processor core clock.
*/
package dti_pkg;

  // ****************************************
  // Register map (byte addresses).
  // ****************************************
  localparam logic [11:0] OFS_CTRL = 12'h000;    // Rounding control and masks.
  localparam logic [11:0] OFS_STATUS = 12'h004;  // Sticky event flags, write one to clear.
  localparam logic [11:0] OFS_IRQMASK = 12'h008; // Interrupt enables, same layout.
  localparam logic [11:0] OFS_RESLO = 12'h00C;   // Last result, low word.
  localparam logic [11:0] OFS_RESHI = 12'h010;   // Last result, high word.

  // ****************************************
  // Field positions and reset values.
  // ****************************************
  localparam int CTRL_RC_LSB = 0;   // Rounding control occupies bits 1:0.
  localparam int CTRL_IM_BIT = 2;   // Invalid exception mask.
  localparam int CTRL_PM_BIT = 3;   // Precision exception mask.
  localparam int EV_INVALID = 0;    // Status and mask bit for invalid.
  localparam int EV_PRECISION = 1;  // Status and mask bit for precision.
  localparam int EV_OPCODE = 2;     // Status and mask bit for invalid opcode.
  localparam logic [3:0] CTRL_RESET = 4'hC;   // Nearest, both exceptions masked.
  localparam logic [2:0] IRQMASK_RESET = 3'h0; // All interrupts disabled.

  // ****************************************
  // Instruction encoding constants.
  // ****************************************
  localparam logic [7:0] PFX_REPNE = 8'hF2;     // Mandatory prefix byte.
  localparam logic [7:0] ESC_TWO_BYTE = 8'h0F;  // Escape byte.
  localparam logic [7:0] OPC_ROUND = 8'h2D;     // Rounding conversion.
  localparam logic [7:0] OPC_TRUNC = 8'h2C;     // Truncating conversion.
  localparam logic [3:0] EXTRA_REG_NONE = 4'hF; // Only legal extra-register field.

  // ****************************************
  // Numeric constants.
  // ****************************************
  localparam logic [10:0] EXP_SPECIAL = 11'h7FF;  // Infinity or NaN exponent.
  localparam logic [10:0] EXP_UNIT_LSB = 11'h433; // Exponent where mantissa LSB weighs one.
  localparam logic [11:0] MAX_LEFT_SHIFT = 12'h00B; // Larger shifts overflow 64 bits.
  localparam logic [11:0] EXT_WIDTH = 12'h075;    // Width of the alignment vector.
  localparam logic [31:0] INDEF32 = 32'h80000000; // Doubleword indefinite value.
  localparam logic [63:0] INDEF64 = 64'h8000000000000000; // Quadword indefinite value.

  // Rounding-control encodings.
  typedef enum logic [1:0] {RC_NEAREST, RC_DOWN, RC_UP, RC_ZERO} dti_rc_t;

  // Register selected by an APB address.
  typedef enum logic [2:0] {SEL_CTRL, SEL_STATUS, SEL_IRQMASK, SEL_RESLO, SEL_RESHI,
    SEL_NONE} dti_sel_t;

  // Instruction fields handed over by the decoder.
  typedef struct packed {
    logic vexForm;
    logic [7:0] prefixByte;
    logic [7:0] escapeByte;
    logic [7:0] opcode;
    logic widthBit;
    logic [3:0] extraReg;
    logic srcMem;
    logic [3:0] destIdx;
  } dti_instr_t;

  // Decode outcome.
  typedef struct packed {
    logic hit;
    logic truncate;
    logic wide;
    logic opFault;
  } dti_dec_t;

  // Conversion outcome.
  typedef struct packed {
    logic [63:0] value;
    logic invalid;
    logic inexact;
  } dti_cvt_t;

  // Software control fields.
  typedef struct packed {
    logic precMask;
    logic invMask;
    dti_rc_t roundCtl;
  } dti_ctrl_t;

  // Whole state of the top module.
  typedef struct packed {
    dti_ctrl_t ctrl;
    logic [2:0] status;
    logic [2:0] irqMask;
    logic [63:0] lastRes;
    logic [31:0] rdData;
    logic gprWe;
    logic gprWide;
    logic [3:0] gprIdx;
    logic [63:0] gprData;
    logic opFault;
    logic simdFault;
    logic precEvent;
  } dti_state_t;

endpackage

//--- logic/dti_decode.sv
/*
 Combinational instruction decode for the converter.
 Assumes the decoder supplies implied prefix and escape bytes for
 vector-prefix forms in the same fields as legacy bytes.
*/
`timescale 1ns/1ps
module dti_decode (
  input wire dti_pkg::dti_instr_t instr,
  input wire logic mode64,
  output dti_pkg::dti_dec_t dec
);

  // ****************************************
  // Decode.
  // ****************************************
  // The width bit only counts in 64-bit mode; elsewhere it is ignored.
  always_comb begin
    dec.hit = (instr.prefixByte == dti_pkg::PFX_REPNE) &&
      (instr.escapeByte == dti_pkg::ESC_TWO_BYTE) &&
      ((instr.opcode == dti_pkg::OPC_ROUND) ||
      (instr.opcode == dti_pkg::OPC_TRUNC));
    dec.truncate = (instr.opcode == dti_pkg::OPC_TRUNC);
    dec.wide = mode64 & instr.widthBit;
    dec.opFault = dec.hit & instr.vexForm &
      (instr.extraReg != dti_pkg::EXTRA_REG_NONE);
  end

endmodule

//--- logic/dti_convert.sv
/*
 Combinational double-precision to signed integer conversion.
 Assumes the caller picks the effective width and rounding mode.
*/
`timescale 1ns/1ps
module dti_convert (
  input wire logic [63:0] src,
  input wire dti_pkg::dti_rc_t roundCtl,
  input wire logic truncate,
  input wire logic wide,
  output dti_pkg::dti_cvt_t res
);

  logic sign;              // Source sign.
  logic [10:0] expo;       // Biased exponent.
  logic [52:0] mant;       // Mantissa with hidden bit.
  logic [11:0] shamt;      // Alignment shift.
  logic [116:0] ext;       // Aligned integer and fraction.
  logic [63:0] intPart;    // Truncated magnitude.
  logic rndBit;            // First dropped bit.
  logic stkBit;            // Or of the remaining dropped bits.
  logic inc;               // Round-up decision.
  logic over;              // Out of range or not a number.
  logic [64:0] mag;        // Rounded magnitude.
  logic [64:0] lim;        // Magnitude of the most negative integer.
  logic [63:0] sres;       // Signed result.
  dti_pkg::dti_rc_t mode;  // Effective rounding mode.

  // ****************************************
  // Alignment, rounding and range check.
  // ****************************************
  // A wide shift vector keeps every dropped bit visible to the sticky logic up to a shift of 64, and the hidden bit up to 116.
  always_comb begin
    sign = src[63];
    expo = src[62:52];
    mant = {(expo != 11'h000), src[51:0]};
    shamt = 12'h000;
    ext = '0;
    intPart = 64'h0;
    rndBit = 1'b0;
    stkBit = 1'b0;
    over = 1'b0;
    if (expo == dti_pkg::EXP_SPECIAL) begin
      over = 1'b1;
    end else if (expo >= dti_pkg::EXP_UNIT_LSB) begin
      shamt = {1'b0, expo} - {1'b0, dti_pkg::EXP_UNIT_LSB};
      if (shamt > dti_pkg::MAX_LEFT_SHIFT) begin
        over = 1'b1;
      end else begin
        intPart = {11'h000, mant} << shamt[3:0];
      end
    end else begin
      shamt = {1'b0, dti_pkg::EXP_UNIT_LSB} - {1'b0, expo};
      if (shamt >= dti_pkg::EXT_WIDTH) begin
        stkBit = |mant;
      end else begin
        ext = {mant, 64'h0} >> shamt;
        intPart = {11'h000, ext[116:64]};
        rndBit = ext[63];
        stkBit = |ext[62:0];
      end
    end
    mode = truncate ? dti_pkg::RC_ZERO : roundCtl;
    unique case (mode)
      dti_pkg::RC_NEAREST: inc = rndBit & (stkBit | intPart[0]);
      dti_pkg::RC_DOWN: inc = sign & (rndBit | stkBit);
      dti_pkg::RC_UP: inc = ~sign & (rndBit | stkBit);
      dti_pkg::RC_ZERO: inc = 1'b0;
    endcase
    mag = {1'b0, intPart} + {64'h0, inc};
    lim = wide ? {1'b0, dti_pkg::INDEF64} : {33'h0, dti_pkg::INDEF32};
    if (sign ? (mag > lim) : (mag >= lim)) begin
      over = 1'b1;
    end
    sres = sign ? (~mag[63:0] + 64'h1) : mag[63:0];
    res.invalid = over;
    res.inexact = ~over & (rndBit | stkBit);
    if (over) begin
      res.value = wide ? dti_pkg::INDEF64 : {32'h0, dti_pkg::INDEF32};
    end else begin
      res.value = wide ? sres : {32'h0, sres[31:0]};
    end
  end

endmodule

//--- logic/dti_converter.sv
/*
 Top of the double-to-integer converter: APB registers, issue, result
 write-back, exception events and interrupt.
 Assumes the decoder and register file run on clk and hold instruction
 fields and operands valid in the cycle that issue is high.
*/
// Overview of operation
// - Source from memory or vector low quadword.
// - Rounding form obeys control register rounding field.
// - Truncating form always rounds toward zero.
// - 32-bit overflow: invalid, masked writes 80000000H.
// - 64-bit overflow: invalid, masked writes quadword indefinite.
// - Legacy width bit gives 64-bit in 64-bit mode.
// - Vector width bit ignored outside 64-bit mode.
// - Vector extra-register field not 1111b faults.
// - Opcode 2D after F2 0F rounds.
// - Opcode 2C after F2 0F truncates.
// - 64-bit result fills whole destination register.
`timescale 1ns/1ps
module dti_converter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issue,
  input wire dti_pkg::dti_instr_t instr,
  input wire logic mode64,
  input wire logic [63:0] vecLow,
  input wire logic [63:0] memOperand,
  output logic gprWe,
  output logic gprWide,
  output logic [3:0] gprIdx,
  output logic [63:0] gprData,
  output logic opFault,
  output logic simdFault,
  output logic precEvent,
  output logic irq
);

  // ****************************************
  // Address decode.
  // ****************************************
  // Shared by the read path, the write path and the error answer.
  function automatic dti_pkg::dti_sel_t regSel(input logic [11:0] a);
    unique case (a)
      dti_pkg::OFS_CTRL: regSel = dti_pkg::SEL_CTRL;
      dti_pkg::OFS_STATUS: regSel = dti_pkg::SEL_STATUS;
      dti_pkg::OFS_IRQMASK: regSel = dti_pkg::SEL_IRQMASK;
      dti_pkg::OFS_RESLO: regSel = dti_pkg::SEL_RESLO;
      dti_pkg::OFS_RESHI: regSel = dti_pkg::SEL_RESHI;
      default: regSel = dti_pkg::SEL_NONE;
    endcase
  endfunction

  dti_pkg::dti_state_t state_r;   // Registered state.
  dti_pkg::dti_state_t state_nxt; // Next state.
  dti_pkg::dti_dec_t dec;         // Decode outcome.
  dti_pkg::dti_cvt_t cvt;         // Conversion outcome.
  dti_pkg::dti_sel_t selNow;      // Register under the current address.
  logic [63:0] srcOperand;        // Selected source value.
  logic accepted;                 // A recognised instruction issues.
  logic wrAccess;                 // APB write completes this edge.
  logic rdSetup;                  // APB read setup cycle.
  logic [2:0] events;             // Events raised this cycle.
  logic [2:0] clearBits;          // Status bits software clears.
  logic doWrite;                  // Destination register is written.

  // ****************************************
  // Source selection and datapath.
  // ****************************************
  // The source is either the memory operand or the low vector quadword.
  assign srcOperand = instr.srcMem ? memOperand : vecLow;

  dti_decode uDecode (
    .instr(instr),
    .mode64(mode64),
    .dec(dec)
  );

  dti_convert uConvert (
    .src(srcOperand),
    .roundCtl(state_r.ctrl.roundCtl),
    .truncate(dec.truncate),
    .wide(dec.wide),
    .res(cvt)
  );

  // ****************************************
  // Bus handshake.
  // ****************************************
  // The slave never waits, so every access finishes in two cycles.
  assign selNow = regSel(paddr);
  assign pready = 1'b1;
  assign pslverr = psel & penable & (selNow == dti_pkg::SEL_NONE);
  assign wrAccess = psel & penable & pwrite;
  assign rdSetup = psel & ~penable & ~pwrite;
  assign accepted = issue & dec.hit;

  // ****************************************
  // Next-state logic.
  // ****************************************
  // A faulting opcode produces no conversion events and no write-back.
  always_comb begin
    state_nxt = state_r;
    events = 3'h0;
    clearBits = 3'h0;
    doWrite = 1'b0;
    state_nxt.gprWe = 1'b0;
    state_nxt.opFault = 1'b0;
    state_nxt.simdFault = 1'b0;
    state_nxt.precEvent = 1'b0;
    if (accepted) begin
      if (dec.opFault) begin
        events[dti_pkg::EV_OPCODE] = 1'b1;
        state_nxt.opFault = 1'b1;
      end else begin
        events[dti_pkg::EV_INVALID] = cvt.invalid;
        events[dti_pkg::EV_PRECISION] = cvt.inexact;
        state_nxt.precEvent = cvt.inexact;
        // An unmasked exception traps, so the destination is kept.
        state_nxt.simdFault = (cvt.invalid & ~state_r.ctrl.invMask) |
          (cvt.inexact & ~state_r.ctrl.precMask);
        doWrite = ~state_nxt.simdFault;
      end
    end
    if (doWrite) begin
      state_nxt.gprWe = 1'b1;
      state_nxt.gprWide = dec.wide;
      state_nxt.gprIdx = instr.destIdx;
      state_nxt.gprData = cvt.value;
      state_nxt.lastRes = cvt.value;
    end
    // Register writes take effect at the access edge only.
    if (wrAccess) begin
      unique case (selNow)
        dti_pkg::SEL_CTRL: begin
          state_nxt.ctrl = pwdata[dti_pkg::CTRL_PM_BIT:dti_pkg::CTRL_RC_LSB];
        end
        dti_pkg::SEL_STATUS: begin
          clearBits = pwdata[2:0];
        end
        dti_pkg::SEL_IRQMASK: begin
          state_nxt.irqMask = pwdata[2:0];
        end
        default: begin
          state_nxt.irqMask = state_r.irqMask;
        end
      endcase
    end
    // A new event wins over a clear in the same cycle.
    state_nxt.status = (state_r.status & ~clearBits) | events;
    // Read data is captured in the setup cycle and stands through access.
    if (rdSetup) begin
      unique case (selNow)
        dti_pkg::SEL_CTRL: state_nxt.rdData = {28'h0, state_r.ctrl};
        dti_pkg::SEL_STATUS: state_nxt.rdData = {29'h0, state_r.status};
        dti_pkg::SEL_IRQMASK: state_nxt.rdData = {29'h0, state_r.irqMask};
        dti_pkg::SEL_RESLO: state_nxt.rdData = state_r.lastRes[31:0];
        dti_pkg::SEL_RESHI: state_nxt.rdData = state_r.lastRes[63:32];
        default: state_nxt.rdData = 32'h0;
      endcase
    end
  end

  // ****************************************
  // State register.
  // ****************************************
  // Synchronous reset to fixed constants only.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= '0;
      state_r.ctrl <= dti_pkg::CTRL_RESET;
      state_r.irqMask <= dti_pkg::IRQMASK_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // Outputs.
  // ****************************************
  // Every data output comes straight from the state register.
  assign prdata = state_r.rdData;
  assign gprWe = state_r.gprWe;
  assign gprWide = state_r.gprWide;
  assign gprIdx = state_r.gprIdx;
  assign gprData = state_r.gprData;
  assign opFault = state_r.opFault;
  assign simdFault = state_r.simdFault;
  assign precEvent = state_r.precEvent;
  // The interrupt is a level that follows the masked sticky flags.
  assign irq = |(state_r.status & state_r.irqMask);

endmodule

//--- tb/dti_converter_props.sv
/* Concurrent checks on the converter top ports.
   Assumes one clock domain with a synchronous active-low reset. */
`timescale 1ns/1ps
module dti_converter_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pslverr,
  input wire logic issue,
  input wire dti_pkg::dti_instr_t instr,
  input wire logic mode64,
  input wire logic [63:0] vecLow,
  input wire logic [63:0] memOperand,
  input wire logic gprWe,
  input wire logic gprWide,
  input wire logic [3:0] gprIdx,
  input wire logic [63:0] gprData,
  input wire logic opFault,
  input wire logic simdFault
);
  // ****
  // Decode as seen from the ports.
  // ****
  logic [63:0] src; // Operand that the issue selects.
  logic hit; // A recognised conversion is issued.
  logic bad; // Vector form with the extra field in use.
  logic nan; // Infinity or NaN source.
  logic wide; // Quadword destination asked for.
  assign src = instr.srcMem ? memOperand : vecLow;
  assign hit = issue && instr.prefixByte == dti_pkg::PFX_REPNE &&
    instr.escapeByte == dti_pkg::ESC_TWO_BYTE &&
    (instr.opcode == dti_pkg::OPC_ROUND || instr.opcode == dti_pkg::OPC_TRUNC);
  assign bad = hit && instr.vexForm && instr.extraReg != dti_pkg::EXTRA_REG_NONE;
  assign nan = src[62:52] == dti_pkg::EXP_SPECIAL;
  assign wide = mode64 && instr.widthBit;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ****
  // Assertions.
  // ****
  op_fault_a: assert property (bad |=> opFault && !gprWe && !simdFault)
    else $error("Reserved field did not fault");
  lone_write_a: assert property (!hit |=> !gprWe)
    else $error("Write without a recognised issue");
  write_width_a: assert property (hit && !bad |=> !gprWe || gprWide == $past(wide))
    else $error("Destination width wrong");
  dest_index_a: assert property (hit |=> !gprWe || gprIdx == $past(instr.destIdx))
    else $error("Destination index wrong");
  narrow_zero_a: assert property (gprWe && !gprWide |-> gprData[63:32] == 32'h0)
    else $error("Narrow result has upper bits");
  // A masked invalid source must give the indefinite value of the chosen width.
  indef_value_a: assert property (hit && !bad && nan |=> !gprWe ||
    gprData == ($past(wide) ? dti_pkg::INDEF64 : {32'h0, dti_pkg::INDEF32}))
    else $error("Indefinite value wrong");
  trap_no_write_a: assert property (simdFault |-> !gprWe)
    else $error("Write despite trap");
  unmapped_err_a: assert property (psel && penable && paddr > dti_pkg::OFS_RESHI |-> pslverr)
    else $error("Unmapped access not refused");
endmodule
bind dti_converter dti_converter_props chk (.clk, .rst_n, .psel, .penable, .paddr,
  .pslverr, .issue, .instr, .mode64, .vecLow, .memOperand, .gprWe, .gprWide, .gprIdx,
  .gprData, .opFault, .simdFault);

//--- tb/dti_gpr_model.sv
/* Register file model on the far side of the converter write port.
   Assumes writes arrive as one-cycle strobes on the core clock. */
`timescale 1ns/1ps
module dti_gpr_model (
  input wire logic clk,
  input wire logic gprWe,
  input wire logic gprWide,
  input wire logic [3:0] gprIdx,
  input wire logic [63:0] gprData
);
  // ****
  // Sixteen general-purpose registers.
  // ****
  logic [63:0] regs [16]; // Read by the bench through the instance name.
  initial begin
    foreach (regs[i]) regs[i] = 64'h0;
  end
  // A narrow write keeps the upper half, so a wrongly wide write shows up.
  always @(posedge clk) begin
    if (gprWe && gprWide) begin
      regs[gprIdx] <= gprData;
    end else if (gprWe) begin
      regs[gprIdx][31:0] <= gprData[31:0];
    end
  end
endmodule

//--- tb/tb.sv
/* Self-checking bench for the converter: APB and issue traffic.
   Assumes the design package, the checker and the register file model. */
`timescale 1ns/1ps
module tb;
  // ****
  // Signals.
  // ****
  logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic issue = 1'h0, mode64 = 1'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, gprWe, gprWide, opFault, simdFault, precEvent, irq, lastErr;
  logic [3:0] gprIdx;
  logic [63:0] gprData, sData, vecLow = 64'h0, memOperand = 64'h0;
  dti_pkg::dti_instr_t instr = '0;
  logic sWe, sWide, sOp, sTrap, sPrec; // Outputs seen one cycle after issue.
  int nFail = 0, nCompared = 0, cyc = 0;
  logic [63:0] expPos [4] = '{64'h2, 64'h1, 64'h2, 64'h1}; // 1.5 per rounding mode.
  logic [63:0] expNeg [4] = '{64'hFFFFFFFE, 64'hFFFFFFFE, 64'hFFFFFFFF, 64'hFFFFFFFF};
  localparam real INF = 1.0e308 * 10.0; // Overflows to infinity.

  always #2 clk = ~clk;

  dti_converter uut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .issue, .instr, .mode64, .vecLow, .memOperand, .gprWe, .gprWide,
    .gprIdx, .gprData, .opFault, .simdFault, .precEvent, .irq);
  dti_gpr_model gm (.clk, .gprWe, .gprWide, .gprIdx, .gprData);

  // ****
  // Tasks.
  // ****
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nFail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; the wait is open-ended so a slow answer is still accepted.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    q = prdata;
    lastErr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Issue one instruction; the other source gets the inverse so a wrong pick shows.
  task automatic run(input logic [7:0] opc, input logic vex, input logic w,
    input logic [3:0] xr, input logic m64, input logic mem, input logic [3:0] idx,
    input real v);
    @(posedge clk);
    issue <= 1'h1;
    instr <= '{vex, dti_pkg::PFX_REPNE, dti_pkg::ESC_TWO_BYTE, opc, w, xr, mem, idx};
    mode64 <= m64;
    memOperand <= mem ? $realtobits(v) : ~$realtobits(v);
    vecLow <= mem ? ~$realtobits(v) : $realtobits(v);
    @(posedge clk);
    issue <= 1'h0;
    @(negedge clk);
    {sWe, sWide, sOp, sTrap, sPrec, sData} = {gprWe, gprWide, opFault, simdFault,
      precEvent, gprData};
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A hang is cut short well beyond the hundred or so cycles the run needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      nFail++;
      final_report();
    end
  end

  // ****
  // Main sequence.
  // ****
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h0, dti_pkg::OFS_CTRL, 32'h0);
    chk(q, 64'hC);
    apb(1'h0, 12'h040, 32'h0);
    chk({lastErr, q}, 64'h100000000);
    // Every rounding mode, alternating the source between memory and vector.
    for (int r = 0; r < 4; r++) begin
      apb(1'h1, dti_pkg::OFS_CTRL, 32'hC | r);
      run(dti_pkg::OPC_ROUND, 1'h0, 1'h0, 4'hF, 1'h1, r[0], 4'h1, 1.5);
      chk(sData, expPos[r]);
      chk(sPrec, 64'h1);
      run(dti_pkg::OPC_ROUND, 1'h0, 1'h0, 4'hF, 1'h1, ~r[0], 4'h1, -1.5);
      chk(sData, expNeg[r]);
      run(dti_pkg::OPC_TRUNC, 1'h1, 1'h0, 4'hF, 1'h1, r[0], 4'h2, -2.7);
      chk(sData, 64'hFFFFFFFE);
    end
    apb(1'h1, dti_pkg::OFS_CTRL, 32'hC);
    run(dti_pkg::OPC_ROUND, 1'h0, 1'h0, 4'hF, 1'h1, 1'h1, 4'h3, 3.0e9);
    chk(sData, {32'h0, dti_pkg::INDEF32});
    run(dti_pkg::OPC_ROUND, 1'h0, 1'h1, 4'hF, 1'h1, 1'h1, 4'h3, 3.0e9);
    chk({sWide, sData}, {1'h1, 64'hB2D05E00});
    run(dti_pkg::OPC_TRUNC, 1'h1, 1'h1, 4'hF, 1'h1, 1'h0, 4'h3, 1.0e19);
    chk(sData, dti_pkg::INDEF64);
    run(dti_pkg::OPC_TRUNC, 1'h1, 1'h1, 4'hF, 1'h0, 1'h1, 4'h3, INF);
    chk({sWide, sData}, {1'h0, 32'h0, dti_pkg::INDEF32});
    run(dti_pkg::OPC_ROUND, 1'h0, 1'h1, 4'hF, 1'h1, 1'h0, 4'h5, -3.0);
    chk({sPrec, sData}, {1'h0, 64'hFFFFFFFFFFFFFFFD});
    run(dti_pkg::OPC_ROUND, 1'h0, 1'h0, 4'hF, 1'h1, 1'h0, 4'h5, 7.0);
    @(negedge clk);
    chk(gm.regs[5], 64'hFFFFFFFF00000007);
    run(8'h2E, 1'h0, 1'h0, 4'hF, 1'h1, 1'h0, 4'h5, 7.0);
    chk({sWe, sOp}, 64'h0);
    // Reserved field fault raises the interrupt until cleared.
    apb(1'h1, dti_pkg::OFS_STATUS, 32'h7);
    apb(1'h1, dti_pkg::OFS_IRQMASK, 32'h7);
    run(dti_pkg::OPC_ROUND, 1'h1, 1'h0, 4'h0, 1'h1, 1'h0, 4'h1, 1.0);
    chk({sOp, sWe, irq}, 64'h5);
    apb(1'h0, dti_pkg::OFS_STATUS, 32'h0);
    chk(q, 64'h4);
    apb(1'h1, dti_pkg::OFS_STATUS, 32'h7);
    @(negedge clk);
    chk(irq, 64'h0);
    // Unmasked invalid, then unmasked precision: trap and no write.
    apb(1'h1, dti_pkg::OFS_CTRL, 32'h8);
    run(dti_pkg::OPC_ROUND, 1'h0, 1'h0, 4'hF, 1'h1, 1'h0, 4'h1, 3.0e9);
    chk({sTrap, sWe}, 64'h2);
    apb(1'h1, dti_pkg::OFS_CTRL, 32'h4);
    run(dti_pkg::OPC_TRUNC, 1'h0, 1'h0, 4'hF, 1'h1, 1'h0, 4'h1, 2.5);
    chk({sTrap, sPrec, sWe}, 64'h6);
    apb(1'h0, dti_pkg::OFS_STATUS, 32'h0);
    chk({irq, q}, 64'h100000003);
    apb(1'h1, dti_pkg::OFS_IRQMASK, 32'h0);
    @(negedge clk);
    chk(irq, 64'h0);
    final_report();
  end
endmodule
